// file: design/bisl_top.sv
// top: apb slave, live status bits, event interrupt with mask
//
// Decided for this implementation: the APB register port and the placing of the registers.
`default_nettype none
module bisl_top (
    input  wire logic               pclk,      // apb clock, 200 MHz
    input  wire logic               presetn,   // async reset, low
    input  wire logic               psel,      // apb select
    input  wire logic               penable,   // apb access phase
    input  wire logic               pwrite,    // apb direction
    input  wire logic [7:0]         paddr,     // apb byte address
    input  wire logic [31:0]        pwdata,    // apb write data
    output logic [31:0]             prdata,    // apb read data
    output logic                    pready,    // apb ready
    output logic                    pslverr,   // apb error
    input  wire bisl_pkg::bisl_hw_t hw,        // hardware events
    output logic                    irq        // level interrupt
);
    localparam int EW = bisl_pkg::EXC_W;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
        logic [7:0]  ctrl;
        logic [4:0]  istat;
        logic [4:0]  imask;
        logic        remote;   // registered remote line
        logic        fifo;     // registered fifo level
    } bisl_top_t;
    bisl_top_t s_q, s_d; // whole state

    logic          exc_flag;  // from flag core
    logic [EW-1:0] exc_cause; // from flag core
    logic          tc_flag;   // from flag core
    logic          won_flag;  // from flag core
    logic          exc_rd;    // detail read pulse
    logic          setup;     // apb setup cycle seen
    logic [7:0]    status;    // assembled status byte
    logic [4:0]    events;    // event levels for istat

    // flag core; enables come straight from the control register
    bisl_flags #(.EXC_W(EW)) u_flags (
        .pclk      (pclk),
        .presetn   (presetn),
        .hw        (hw),
        .tc_en     (s_q.ctrl[bisl_pkg::TC_EN_BIT]),
        .won_en    (s_q.ctrl[bisl_pkg::WON_EN_BIT]),
        .exc_rd    (exc_rd),
        .exc_flag  (exc_flag),
        .exc_cause (exc_cause),
        .tc_flag   (tc_flag),
        .won_flag  (won_flag)
    );

    // no wait state: answer is given in the first access cycle, so
    // the side effects fire in setup and land once
    assign setup  = psel && !penable;
    assign exc_rd = setup && !pwrite && (paddr == bisl_pkg::EXC_OFS);

    // status byte; reading it changes nothing
    always_comb begin
        status = 8'h00;
        status[bisl_pkg::REMOTE_HI_BIT] = s_q.remote;
        status[bisl_pkg::REMOTE_LO_BIT] = s_q.remote;  // same as bit 6
        status[bisl_pkg::EXC_FLAG_BIT]  = exc_flag;
        status[bisl_pkg::TC_FLAG_BIT]   = tc_flag;
        status[bisl_pkg::WON_FLAG_BIT]  = won_flag;
        status[bisl_pkg::FIFO_BIT]      = s_q.fifo;
        status[bisl_pkg::SUMMARY_BIT]   = |status[6:0];
    end

    // event register follows source levels, so a source still high sets
    // its bit again in the same cycle that a read clears it, and the bit stays set
    assign events = {s_q.remote, exc_flag, tc_flag, won_flag, s_q.fifo};

    // bus, event and interrupt next state
    always_comb begin
        s_d        = s_q;
        s_d.remote = hw.remote_irq;
        s_d.fifo   = hw.fifo_not_empty;
        s_d.ready  = setup;
        s_d.err    = 1'b0;
        s_d.rdata  = 32'h0000_0000;
        if (setup) begin
            unique case (paddr)
                bisl_pkg::STATUS_OFS: s_d.rdata[7:0] = status;
                bisl_pkg::CONTROL_OFS: begin
                    s_d.rdata[7:0] = s_q.ctrl;
                    if (pwrite) begin
                        s_d.ctrl = pwdata[7:0]; // clearing an enable clears flag
                    end
                end
                bisl_pkg::EXC_OFS: begin
                    // cause and flag; the read drops the flag
                    s_d.rdata[bisl_pkg::EXC_LSB +: EW]   = exc_cause;
                    s_d.rdata[bisl_pkg::EXC_FLAG_BIT]     = exc_flag;
                end
                bisl_pkg::ISTAT_OFS: s_d.rdata[4:0] = s_q.istat;
                bisl_pkg::IMASK_OFS: begin
                    s_d.rdata[4:0] = s_q.imask;
                    if (pwrite) begin
                        s_d.imask = pwdata[4:0];
                    end
                end
                default: s_d.err = 1'b1; // unmapped address
            endcase
        end
        // read clears istat; a new event in the same cycle wins
        if (setup && !pwrite && paddr == bisl_pkg::ISTAT_OFS) begin
            s_d.istat = 5'h00;
        end
        s_d.istat = s_d.istat | events;
        s_d.irq   = |(s_d.istat & s_d.imask);
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.ctrl  <= bisl_pkg::CONTROL_RST;
            s_q.imask <= bisl_pkg::IMASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.rdata;
    assign pready  = s_q.ready;
    assign pslverr = s_q.err;
    assign irq     = s_q.irq;
endmodule
`default_nettype wire

// file: design/bisl_pkg.sv
// package: register map, field positions, reset values and carrier types for the status block
// Functional notes
// - bit 4 mirrors remote irq, equals bit 6
// - bit 3 set after excepted master transfer
// - exception cause shown in bits 11 to 8
// - reading exception bits clears bit 3
// - bit 2 sets on dma terminal count
// - clearing its enable or reset clears bit 2
// - bit 1 sets on winning bus arbitration
// - clearing its enable or reset clears bit 1
// - bit 0 high while signal fifo non-empty
// - bit 7 is OR of bits 6 to 0
`default_nettype none
package bisl_pkg;
    // register byte offsets on the apb
    localparam logic [7:0] STATUS_OFS  = 8'h00; // board status, read only
    localparam logic [7:0] CONTROL_OFS = 8'h04; // irq enables, read/write
    localparam logic [7:0] EXC_OFS     = 8'h08; // exception detail, read clears flag
    localparam logic [7:0] ISTAT_OFS   = 8'h0c; // sticky events, read clears
    localparam logic [7:0] IMASK_OFS   = 8'h10; // mask for irq output
    // status field positions
    localparam int SUMMARY_BIT    = 7;
    localparam int REMOTE_HI_BIT  = 6;
    localparam int REMOTE_LO_BIT  = 4;
    localparam int EXC_FLAG_BIT   = 3;
    localparam int TC_FLAG_BIT    = 2;
    localparam int WON_FLAG_BIT   = 1;
    localparam int FIFO_BIT       = 0;
    localparam int EXC_LSB        = 8;  // detail sits in bits 11:8
    localparam int EXC_W          = 4;
    // control field positions (enables)
    localparam int TC_EN_BIT      = 2;
    localparam int WON_EN_BIT     = 1;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [4:0] IMASK_RST   = 5'h00;
    // interrupt event layout (istat/imask bits)
    localparam int EV_W = 5;
    // hardware events toward the status block
    typedef struct packed {
        logic             remote_irq;     // live remote interrupt line
        logic             master_done;    // pulse: master transfer finished
        logic             master_exc;     // with master_done: it failed
        logic [EXC_W-1:0] exc_cause;      // with master_done: cause code
        logic             dma_tc;         // pulse: last dma transfer done
        logic             arb_won;        // pulse: arbitration won
        logic             fifo_not_empty; // level from signal fifo
    } bisl_hw_t;
endpackage
`default_nettype wire

// file: design/bisl_flags.sv
// flag core: sticky status bits and their set/clear logic
`default_nettype none
module bisl_flags #(
    parameter int EXC_W = 4
) (
    input  wire logic             pclk,        // clock
    input  wire logic             presetn,     // async reset, low
    input  wire bisl_pkg::bisl_hw_t hw,        // hardware events
    input  wire logic             tc_en,       // terminal count enable
    input  wire logic             won_en,      // bus won enable
    input  wire logic             exc_rd,      // pulse: detail register read
    output logic                  exc_flag,    // master exception flag
    output logic [EXC_W-1:0]      exc_cause,   // latched cause
    output logic                  tc_flag,     // terminal count flag
    output logic                  won_flag     // bus won flag
);
    typedef struct packed {
        logic             exc;
        logic [EXC_W-1:0] cause;
        logic             tc;
        logic             won;
    } bisl_fl_t;
    bisl_fl_t s_q, s_d; // whole state

    // next state; a finished transfer wins over a detail-read clear, a cleared enable wins over a set
    always_comb begin
        s_d = s_q;
        if (exc_rd) begin
            s_d.exc = 1'b0;
        end
        if (hw.master_done) begin
            s_d.exc   = hw.master_exc; // last transfer decides
            s_d.cause = hw.exc_cause;
        end
        if (!tc_en) begin
            s_d.tc = 1'b0;
        end else if (hw.dma_tc) begin
            s_d.tc = 1'b1;
        end
        if (!won_en) begin
            s_d.won = 1'b0;
        end else if (hw.arb_won) begin
            s_d.won = 1'b1;
        end
    end

    // registers; hard reset clears every flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign exc_flag  = s_q.exc;
    assign exc_cause = s_q.cause;
    assign tc_flag   = s_q.tc;
    assign won_flag  = s_q.won;
endmodule
`default_nettype wire

// file: tb/bisl_props.sv
// checker: apb answer and status relations seen at the top ports
`default_nettype none
module bisl_props (
    input wire logic               pclk,    // clock
    input wire logic               presetn, // reset, low
    input wire logic               psel,    // select
    input wire logic               penable, // access phase
    input wire logic               pwrite,  // direction
    input wire logic [7:0]         paddr,   // address
    input wire logic [31:0]        pwdata,  // write data
    input wire logic [31:0]        prdata,  // read data
    input wire logic               pready,  // ready
    input wire logic               pslverr, // error
    input wire bisl_pkg::bisl_hw_t hw,      // events
    input wire logic               irq      // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // answer cycle of a status read
    wire logic st_rd = pready && !pwrite && paddr == bisl_pkg::STATUS_OFS;
    // detail read setup with no transfer finishing alongside
    sequence exc_setup;
        psel && !penable && !pwrite && paddr == bisl_pkg::EXC_OFS && !hw.master_done;
    endsequence
    a_remote_twin: assert property (st_rd |-> prdata[6] == prdata[4])
        else $error("remote bits differ");
    a_summary_or: assert property (st_rd |-> prdata[7] == |prdata[6:0])
        else $error("summary bit wrong");
    // second of two close detail reads must see the flag gone
    a_exc_clear: assert property (exc_setup ##1 (pready && !hw.master_done)
        ##1 !hw.master_done ##1 exc_setup |=> !prdata[3]) else $error("exception flag kept");
    a_rdy_follow: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_rdy_once: assert property (pready |=> !pready) else $error("ready held");
    a_err_unmap: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_ok_mapped: assert property (pready && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped refused");
    a_irq_masked: assert property (psel && !penable && pwrite && paddr == bisl_pkg::IMASK_OFS
        && pwdata[4:0] == 5'h00 |-> ##2 !irq) else $error("masked irq high");
endmodule
bind bisl_top bisl_props bisl_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw(hw), .irq(irq));
`default_nettype wire

// file: tb/bisl_hw_model.sv
// event source standing in for host processor, dma and arbiter
`default_nettype none
module bisl_hw_model (
    input  wire logic               pclk,   // clock
    input  wire logic               remote, // remote line level
    input  wire logic               fifo,   // fifo level
    output wire bisl_pkg::bisl_hw_t hw      // events to block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cause_q = 4'h0; // cause travels with done
    logic [3:0] ev_q    = 4'h0; // done, exc, tc, won; driven by pulse only
    logic [1:0] lv_q    = 2'h0; // remote, fifo levels
    // levels pass one edge later, like a pin resync
    always @(posedge pclk) begin
        lv_q <= {remote, fifo};
    end
    assign hw = '{lv_q[1], ev_q[3], ev_q[2], cause_q, ev_q[1], ev_q[0], lv_q[0]};
    // one-cycle pulse: 0 done, 1 tc, 2 won
    task automatic pulse(input int w, input logic e, input logic [3:0] c);
        @(posedge pclk);
        cause_q <= c;
        ev_q    <= {w == 0, e, w == 1, w == 2};
        @(posedge pclk);
        ev_q    <= {1'b0, e, 2'b00};
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// bench: apb tasks and scenarios for the status, detail, event and irq registers
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic               pwrite = 1'b0, remote = 1'b0, fifo = 1'b0, pready, pslverr, irq, err;
    logic [7:0]         paddr = 8'h00;  // byte address
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    bisl_pkg::bisl_hw_t hw;             // model to block
    int                 errors = 0, total_checks = 0;
    bisl_top bisl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw(hw), .irq(irq));
    bisl_hw_model bisl_hw_model_inst (.pclk(pclk), .remote(remote), .fifo(fifo), .hw(hw));
    initial forever #2.5 pclk = ~pclk;
    task automatic test_done;
        $display("errors %0d total_checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer; the leading edge keeps an idle cycle between calls
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) errors++;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rd, x);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(bisl_pkg::CONTROL_OFS, 32'h0, "control");
        rdc(bisl_pkg::IMASK_OFS, 32'h0, "imask");
        {remote, fifo} <= 2'b11;
        repeat (3) @(posedge pclk);
        rdc(bisl_pkg::STATUS_OFS, 32'hd1, "status lv");
        {remote, fifo} <= 2'b00;
        bisl_hw_model_inst.pulse(1, 1'b0, 4'h0);
        bisl_hw_model_inst.pulse(2, 1'b0, 4'h0);
        rdc(bisl_pkg::STATUS_OFS, 32'h0, "status off");
        apb(1'b1, bisl_pkg::CONTROL_OFS, 32'h6);
        bisl_hw_model_inst.pulse(1, 1'b0, 4'h0);
        bisl_hw_model_inst.pulse(2, 1'b0, 4'h0);
        rdc(bisl_pkg::STATUS_OFS, 32'h86, "status fl");
        rdc(bisl_pkg::STATUS_OFS, 32'h86, "status re");
        apb(1'b1, bisl_pkg::CONTROL_OFS, 32'h0);
        rdc(bisl_pkg::STATUS_OFS, 32'h0, "status clr");
        bisl_hw_model_inst.pulse(0, 1'b1, 4'ha);
        rdc(bisl_pkg::STATUS_OFS, 32'h88, "status exc");
        rdc(bisl_pkg::EXC_OFS, 32'ha08, "detail");
        apb(1'b0, bisl_pkg::EXC_OFS, 32'h0);
        chk("detail flag", {28'h0, rd[3:0]}, 32'h0);
        rdc(bisl_pkg::STATUS_OFS, 32'h0, "status exc clr");
        rdc(bisl_pkg::ISTAT_OFS, 32'h1f, "istat all");
        apb(1'b1, bisl_pkg::CONTROL_OFS, 32'h4);
        bisl_hw_model_inst.pulse(1, 1'b0, 4'h0);
        apb(1'b1, bisl_pkg::IMASK_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, bisl_pkg::IMASK_OFS, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, irq}, 32'h1);
        rdc(bisl_pkg::ISTAT_OFS, 32'h4, "istat");
        apb(1'b1, bisl_pkg::CONTROL_OFS, 32'h0);
        apb(1'b0, bisl_pkg::ISTAT_OFS, 32'h0);
        rdc(bisl_pkg::ISTAT_OFS, 32'h0, "istat clr");
        chk("irq off", {31'h0, irq}, 32'h0);
        // hard reset in mid-run drops set flags and enables
        apb(1'b1, bisl_pkg::CONTROL_OFS, 32'h6);
        bisl_hw_model_inst.pulse(1, 1'b0, 4'h0);
        bisl_hw_model_inst.pulse(2, 1'b0, 4'h0);
        rdc(bisl_pkg::STATUS_OFS, 32'h86, "status set");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(bisl_pkg::STATUS_OFS, 32'h0, "status rst");
        rdc(bisl_pkg::CONTROL_OFS, 32'h0, "control rst");
        rdc(8'h20, 32'h0, "unmapped");
        chk("slverr", {31'h0, err}, 32'h1);
        test_done;
    end
    // cut a hang short well past the expected run of about 125 cycles
    initial begin
        #100us;
        errors++;
        test_done;
    end
endmodule
`default_nettype wire
